// ==== core/receiver_control_logic.sv ====
// Receiver control: enables, receive window, filter decode, gain
// shadow and analog preset commands.
// Assumes synchronous inputs on mclk and a controller port that
// delivers register accesses and decoded command codes.
//
// How it works
// - Receive chain powered only while the receiver-enable bit is one.
// - Channel bit chooses both demod channels or a single one.
// - With both channels, a mode bit picks automatic or manual choice.
// - In automatic mode the framing logic picks the feeding channel.
// - Receive window rises when the mask-receive timer expires.
// - Mask command drops the window, unmask command raises it.
// - Window gates strength and framing input, not gain control.
// - Demodulator bit routes amplitude path to peak detector or mixer.
// - Bypass bit feeds input pins straight to gain and filter stages.
// - First-stage gain changes only through configuration register 3.
// - Register 3 resets to the minimum first-stage gain.
// - Filter bits 2..0 select first and third stage zeros.
// - Stage two/three gain reducible in six 3 dB steps.
// - Gain reset clears squelch and copies register 4 into shadow.
// - Filter bits 5..3 select the second-stage low-pass corner.
// - Preset for type A fc/128 loads low-pass 000, zeros clear.
// - Preset for B fc/128 and fc/64 sets only the 200k bit.
// - Preset for fc/32 and fc/16 loads 100 with 80k bit.
// - Peer mode sets 200k and 12k; type F sets 80k and 12k.
// - Preset leaves filters untouched in stream and transparent.
`timescale 1ns/10ps
`include "rx_ctrl_params.svh"

module receiver_control_logic (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire rx_ctrl_pkg::reg_req_t     reg_req,
  output logic [7:0]                     rd_data,
  input  wire rx_ctrl_pkg::cmd_t         cmd,
  input  wire rx_ctrl_pkg::proto_t       proto_mode,
  input  wire logic                      mrt_expire,
  input  wire logic                      framing_pick_pm,
  input  wire logic                      squelch_step,
  input  wire logic                      am_digital,
  input  wire logic                      pm_digital,
  output rx_ctrl_pkg::analog_ctrl_t      analog_ctrl,
  output rx_ctrl_pkg::filter_sel_t       filter_sel,
  output logic                           rx_window,
  output logic                           meas_gate,
  output logic                           framing_data,
  output logic                           gain_reset_pulse
);
  import rx_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------
  // Unused zero codes fall back to the default corners
  function automatic filter_sel_t decode_filter(input logic [7:0] fc);
    filter_sel_t f;
    f = '{ZERO1_60K, ZERO3_400K, LP_1200K, 1'b0};
    case (fc[`FC_ZERO_HI:`FC_ZERO_LO])
      3'h0: f.code_unused = 1'b0;
      3'h4: f.third_zero = ZERO3_200K;
      3'h2: begin
        f.first_zero = ZERO1_40K;
        f.third_zero = ZERO3_80K;
      end
      3'h1, 3'h5: begin
        f.first_zero = ZERO1_12K;
        f.third_zero = ZERO3_200K;
      end
      3'h3: begin
        f.first_zero = ZERO1_12K;
        f.third_zero = ZERO3_80K;
      end
      default: f.code_unused = 1'b1;
    endcase
    case (fc[`FC_LP_HI:`FC_LP_LO])
      3'h0: f.lowpass = LP_1200K;
      3'h1: f.lowpass = LP_600K;
      3'h2: f.lowpass = LP_300K;
      3'h4: f.lowpass = LP_2M;
      3'h5: f.lowpass = LP_7M;
      default: f.code_unused = 1'b1;
    endcase
    return f;
  endfunction : decode_filter

  // Preset value of filter bits 5..0 per protocol
  function automatic logic [5:0] preset_bits(input proto_t p);
    case (p)
      PROTO_ISO_A_128: preset_bits = 6'h00;
      PROTO_ISO_B_128,
      PROTO_ISO_64:    preset_bits = 6'h04;
      PROTO_ISO_32_16: preset_bits = 6'h22;
      PROTO_NFCIP:     preset_bits = 6'h05;
      PROTO_TYPEF:     preset_bits = 6'h03;
      default:         preset_bits = 6'h00;
    endcase
  endfunction : preset_bits

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] op_ctrl_reg;
  logic [7:0] filter_cfg_reg;
  logic [7:0] rx_conf2_reg;
  logic [7:0] rx_conf3_reg;
  logic [7:0] rx_conf4_reg;
  logic [2:0] shadow_red_reg;
  logic [2:0] squelch_red_reg;
  logic [2:0] squelch_red_next;
  logic [7:0] filter_cfg_next;
  logic       rx_window_next;

  // Access and command decode
  wire wr_op   = reg_req.wr_en && reg_req.addr == `OFF_OP_CTRL;
  wire wr_fc   = reg_req.wr_en && reg_req.addr == `OFF_FILTER_CFG;
  wire wr_c2   = reg_req.wr_en && reg_req.addr == `OFF_RX_CONF2;
  wire wr_c3   = reg_req.wr_en && reg_req.addr == `OFF_RX_CONF3;
  wire wr_c4   = reg_req.wr_en && reg_req.addr == `OFF_RX_CONF4;
  wire cmd_mask    = cmd.valid && cmd.code == `CMD_MASK_RX;
  wire cmd_unmask  = cmd.valid && cmd.code == `CMD_UNMASK_RX;
  wire cmd_gainrst = cmd.valid && cmd.code == `CMD_RESET_GAIN;
  wire cmd_preset  = cmd.valid && cmd.code == `CMD_ANALOG_PRE;
  // Stream and transparent have no preset: filters stay as written
  wire preset_ok   = proto_mode != PROTO_STREAM &&
                     proto_mode != PROTO_TRANSPARENT;

  // Preset wins over a write to the filter register in the same cycle
  assign filter_cfg_next = (cmd_preset && preset_ok) ?
      {filter_cfg_reg[7:6], preset_bits(proto_mode)} :
      (wr_fc ? reg_req.wdata : filter_cfg_reg);

  // Clear by command, then a same-cycle squelch step still counts
  wire [2:0] sq_base = cmd_gainrst ? 3'h0 : squelch_red_reg;
  assign squelch_red_next =
      (squelch_step && sq_base < `STAGE23_MAX_RED) ?
      sq_base + 3'h1 : sq_base;

  // Explicit commands override the timer; mask wins over expiry
  assign rx_window_next = cmd_mask ? 1'b0 :
      (cmd_unmask || mrt_expire) ? 1'b1 : rx_window;

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      op_ctrl_reg    <= `RST_OP_CTRL;
      filter_cfg_reg <= `RST_FILTER_CFG;
      rx_conf2_reg   <= `RST_RX_CONF2;
      rx_conf3_reg   <= `RST_RX_CONF3;
      rx_conf4_reg   <= `RST_RX_CONF4;
    end else if (ce) begin
      if (wr_op) op_ctrl_reg <= reg_req.wdata;
      filter_cfg_reg <= filter_cfg_next;
      if (wr_c2) rx_conf2_reg <= reg_req.wdata;
      if (wr_c3) rx_conf3_reg <= reg_req.wdata;
      if (wr_c4) rx_conf4_reg <= reg_req.wdata;
    end
  end

  // Register 4 field reaches past six steps; clip it as it loads
  wire [3:0] conf4_red = rx_conf4_reg[`C4_RED_HI:`C4_RED_LO];
  wire [2:0] conf4_sat = (conf4_red > {1'b0, `STAGE23_MAX_RED}) ?
                         `STAGE23_MAX_RED : conf4_red[2:0];

  // Gain shadow and squelch reduction
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shadow_red_reg  <= 3'h0;
      squelch_red_reg <= 3'h0;
    end else if (ce) begin
      if (cmd_gainrst)
        shadow_red_reg <= conf4_sat;
      squelch_red_reg <= squelch_red_next;
    end
  end

  // ----------------------------------------------------------------
  // Channel and analog control
  // ----------------------------------------------------------------
  wire both_chn = !op_ctrl_reg[`OP_RX_CHN];
  wire auto_sel = both_chn && !op_ctrl_reg[`OP_RX_MAN];
  // Framing decides in auto; otherwise the manual channel bit
  wire pick_pm  = auto_sel ? framing_pick_pm :
                  filter_cfg_reg[`FC_CHAN_MAN];
  wire power_on = op_ctrl_reg[`OP_RX_EN];
  // Larger of shadow and squelch, clipped at the six-step floor
  wire [2:0] red_max = (shadow_red_reg > squelch_red_reg) ?
                       shadow_red_reg : squelch_red_reg;
  wire [2:0] red_sat = (red_max > `STAGE23_MAX_RED) ?
                       `STAGE23_MAX_RED : red_max;
  wire       sel_bit = pick_pm ? pm_digital : am_digital;

  analog_ctrl_t ctrl_next;
  always_comb begin
    ctrl_next.power_en     = power_on;
    ctrl_next.am_en        = power_on && (both_chn || !pick_pm);
    ctrl_next.pm_en        = power_on && (both_chn || pick_pm);
    ctrl_next.chan_pm      = pick_pm;
    ctrl_next.use_mixer    = filter_cfg_reg[`FC_AMD_SEL];
    ctrl_next.lf_bypass    = rx_conf2_reg[`C2_LF_BYPASS];
    ctrl_next.stage1_red   = rx_conf3_reg[`C3_RED_HI:`C3_RED_LO];
    ctrl_next.stage1_boost = rx_conf3_reg[`C3_BOOST];
    ctrl_next.stage23_red  = red_sat;
  end

  // Read mux; status shows window and active reduction
  wire [7:0] rd_mux =
      reg_req.addr == `OFF_OP_CTRL    ? op_ctrl_reg    :
      reg_req.addr == `OFF_FILTER_CFG ? filter_cfg_reg :
      reg_req.addr == `OFF_RX_CONF2   ? rx_conf2_reg   :
      reg_req.addr == `OFF_RX_CONF3   ? rx_conf3_reg   :
      reg_req.addr == `OFF_RX_CONF4   ? rx_conf4_reg   :
      reg_req.addr == `OFF_RX_STATUS  ?
        {rx_window, 1'b0, squelch_red_reg, red_sat} : 8'h00;

  // Output flops; every top output leaves from here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      analog_ctrl      <= '0;
      filter_sel       <= '{ZERO1_60K, ZERO3_400K, LP_1200K, 1'b0};
      rx_window        <= 1'b0;
      meas_gate        <= 1'b0;
      framing_data     <= 1'b0;
      gain_reset_pulse <= 1'b0;
      rd_data          <= 8'h00;
    end else if (ce) begin
      analog_ctrl      <= ctrl_next;
      filter_sel       <= decode_filter(filter_cfg_reg);
      rx_window        <= rx_window_next;
      meas_gate        <= rx_window && power_on;
      framing_data     <= rx_window && sel_bit;
      gain_reset_pulse <= cmd_gainrst;
      if (reg_req.rd_en) rd_data <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Enables and channel choice
  rx_power_a: assert property (ce |=>
      analog_ctrl.power_en == $past(op_ctrl_reg[`OP_RX_EN]))
    else $error("receiver power does not follow enable bit");
  single_chan_a: assert property ((ce && op_ctrl_reg[`OP_RX_CHN]) |=>
      !(analog_ctrl.am_en && analog_ctrl.pm_en))
    else $error("both channels on in single mode");
  auto_pick_a: assert property ((ce && both_chn &&
      !op_ctrl_reg[`OP_RX_MAN]) |=>
      analog_ctrl.chan_pm == $past(framing_pick_pm))
    else $error("auto selection ignores framing choice");
  mixer_sel_a: assert property (ce |=>
      analog_ctrl.use_mixer == $past(filter_cfg_reg[`FC_AMD_SEL]))
    else $error("demodulator choice does not follow its bit");
  lf_bypass_a: assert property (ce |=>
      analog_ctrl.lf_bypass == $past(rx_conf2_reg[`C2_LF_BYPASS]))
    else $error("bypass does not follow its bit");
  // Clock enable low holds the window, analog controls, filter register and read data
  state_freeze_a: assert property (!ce |=>
      $stable(rx_window) && $stable(analog_ctrl) &&
      $stable(filter_cfg_reg) && $stable(rd_data))
    else $error("state moved while clock enable was low");

  // Receive window
  window_open_a: assert property ((ce && mrt_expire && !cmd_mask) |=>
      rx_window)
    else $error("window not raised at timer expiry");
  window_cmd_a: assert property ((ce && cmd_mask) |=> !rx_window
      ##0 (!ce || !(cmd_unmask || mrt_expire)) [*1] |=> !rx_window)
    else $error("mask command did not close window");
  unmask_cmd_a: assert property ((ce && cmd_unmask && !cmd_mask) |=>
      rx_window)
    else $error("unmask command did not open window");
  framing_gate_a: assert property ((ce && !rx_window) |=>
      !framing_data && !meas_gate)
    else $error("framing fed outside receive window");
  meas_open_a: assert property ((ce && rx_window && power_on) |=>
      meas_gate)
    else $error("measurement gate shut in open window");

  // Gain settings
  stage1_hold_a: assert property ((!(ce && wr_c3)) |=>
      $stable(rx_conf3_reg))
    else $error("first-stage gain moved without a write");
  stage1_reset_a: assert property (@(posedge mclk)
      disable iff (1'b0) !rst_n |=> rx_conf3_reg == `RST_RX_CONF3)
    else $error("first-stage gain not minimum after reset");
  gain_shadow_a: assert property ((ce && cmd_gainrst) |=>
      shadow_red_reg == (($past(rx_conf4_reg[7:4]) > 4'h6) ? 3'h6 :
                         $past(rx_conf4_reg[6:4]))
      && squelch_red_reg <= 3'h1)
    else $error("gain reset did not load shadow");
  gain_pulse_a: assert property (ce |=>
      gain_reset_pulse == $past(cmd_gainrst))
    else $error("gain reset pulse wrong");
  red_limit_a: assert property (analog_ctrl.stage23_red <=
      `STAGE23_MAX_RED)
    else $error("stage two/three reduction beyond six steps");
  // Read port returns register 3 when register 3 is addressed
  read_back_a: assert property ((ce && reg_req.rd_en &&
      reg_req.addr == `OFF_RX_CONF3) |=> rd_data == $past(rx_conf3_reg))
    else $error("register 3 read back wrong");

  // Filter decode and presets
  zero_decode_a: assert property (ce &&
      filter_cfg_reg[2:0] == 3'h3 |=> filter_sel.first_zero == ZERO1_12K
      && filter_sel.third_zero == ZERO3_80K)
    else $error("zero code 3 decoded wrong");
  unused_code_a: assert property (ce &&
      filter_cfg_reg[2:0] == 3'h7 |=> filter_sel.code_unused)
    else $error("unused zero code not flagged");
  lp_decode_a: assert property (ce &&
      filter_cfg_reg[5:3] == 3'h5 |=> filter_sel.lowpass == LP_7M)
    else $error("low-pass code 5 decoded wrong");
  preset_a_a: assert property ((ce && cmd_preset &&
      proto_mode == PROTO_ISO_A_128) |=>
      filter_cfg_reg[5:0] == 6'h00)
    else $error("type A preset wrong");
  preset_b_a: assert property ((ce && cmd_preset &&
      (proto_mode == PROTO_ISO_B_128 || proto_mode == PROTO_ISO_64)) |=>
      filter_cfg_reg[5:0] == 6'h04)
    else $error("type B preset wrong");
  preset_fast_a: assert property ((ce && cmd_preset &&
      proto_mode == PROTO_ISO_32_16) |=>
      filter_cfg_reg[5:0] == 6'h22)
    else $error("fast rate preset wrong");
  preset_peer_a: assert property ((ce && cmd_preset &&
      proto_mode == PROTO_NFCIP) |=> filter_cfg_reg[5:0] == 6'h05)
    else $error("peer mode preset wrong");
  preset_typef_a: assert property ((ce && cmd_preset &&
      proto_mode == PROTO_TYPEF) |=> filter_cfg_reg[5:0] == 6'h03)
    else $error("type F preset wrong");
  preset_skip_a: assert property ((ce && cmd_preset && !preset_ok
      && !wr_fc) |=> $stable(filter_cfg_reg))
    else $error("preset touched filters in raw modes");

  // Cover points
  window_rise_c: cover property (ce && mrt_expire ##1 rx_window);
  preset_c:      cover property (ce && cmd_preset && preset_ok);
  gain_reset_c:  cover property (ce && cmd_gainrst && squelch_step);
  auto_pm_c:     cover property (auto_sel && framing_pick_pm ##1
                                 analog_ctrl.chan_pm);
  freeze_c:      cover property (!ce && cmd.valid);

endmodule : receiver_control_logic

// ==== core/rx_ctrl_params.svh ====
// Offsets, field positions, reset values and command codes of the
// receiver control block. Assumes inclusion by bare name.
`ifndef RX_CTRL_PARAMS_SVH
`define RX_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_OP_CTRL      3'h0
`define OFF_FILTER_CFG   3'h1
`define OFF_RX_CONF2     3'h2
`define OFF_RX_CONF3     3'h3
`define OFF_RX_CONF4     3'h4
`define OFF_RX_STATUS    3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OP_RX_EN         6
`define OP_RX_CHN        5
`define OP_RX_MAN        4
`define FC_AMD_SEL       7
`define FC_CHAN_MAN      6
`define FC_LP_HI         5
`define FC_LP_LO         3
`define FC_ZERO_HI       2
`define FC_ZERO_LO       0
`define C2_LF_BYPASS     7
`define C3_RED_HI        7
`define C3_RED_LO        5
`define C3_BOOST         4
`define C4_RED_HI        7
`define C4_RED_LO        4

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define RST_OP_CTRL      8'h00
`define RST_FILTER_CFG   8'h00
`define RST_RX_CONF2     8'h00
`define RST_RX_CONF3     8'hC0
`define RST_RX_CONF4     8'h00
`define STAGE23_MAX_RED  3'h6

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_MASK_RX      8'hD0
`define CMD_UNMASK_RX    8'hD1
`define CMD_RESET_GAIN   8'hD5
`define CMD_ANALOG_PRE   8'hCC

`endif

// ==== core/rx_ctrl_pkg.sv ====
// Types shared by the receiver control block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package rx_ctrl_pkg;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PROTO_ISO_A_128,
    PROTO_ISO_B_128,
    PROTO_ISO_64,
    PROTO_ISO_32_16,
    PROTO_NFCIP,
    PROTO_TYPEF,
    PROTO_STREAM,
    PROTO_TRANSPARENT
  } proto_t;

  typedef enum logic [1:0] {ZERO1_60K, ZERO1_40K, ZERO1_12K} zero1_t;
  typedef enum logic [1:0] {ZERO3_400K, ZERO3_200K, ZERO3_80K} zero3_t;
  typedef enum logic [2:0] {
    LP_1200K, LP_600K, LP_300K, LP_2M, LP_7M
  } lp_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } cmd_t;

  typedef struct packed {
    zero1_t first_zero;
    zero3_t third_zero;
    lp_t    lowpass;
    logic   code_unused;
  } filter_sel_t;

  typedef struct packed {
    logic       power_en;
    logic       am_en;
    logic       pm_en;
    logic       chan_pm;
    logic       use_mixer;
    logic       lf_bypass;
    logic [2:0] stage1_red;
    logic       stage1_boost;
    logic [2:0] stage23_red;
  } analog_ctrl_t;

endpackage : rx_ctrl_pkg

// ==== test/host_model.sv ====
// Controller-side model: register writes, reads and direct commands.
// Assumes the block samples its strobes on the rising edge of mclk.
`timescale 1ns/10ps

module host_model (
  input  wire logic             mclk,
  input  wire logic [7:0]       rd_data,
  output rx_ctrl_pkg::reg_req_t reg_req,
  output rx_ctrl_pkg::cmd_t     cmd
);
  import rx_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Bus idle state
  // ----------------------------------------------------------------
  // Idle fields carry junk so stale values are never mistaken for data
  initial begin
    reg_req = '{1'b0, 1'b0, 3'h7, 8'h5A};
    cmd     = '{1'b0, 8'hA5};
  end

  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  // One-cycle write strobe, taken at the second edge
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : write_reg

  // Read data lands on the taken edge
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b1, a, 8'h3C};
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b0, ~a, 8'hC3};
    #1 d = rd_data;
  endtask : read_reg

  // Mask, unmask, gain reset and preset all go through here
  task automatic send_cmd(input logic [7:0] c);
    @(posedge mclk);
    cmd <= '{1'b1, c};
    @(posedge mclk);
    cmd <= '{1'b0, ~c};
  endtask : send_cmd

endmodule : host_model

// ==== test/test_receiver_control_logic.sv ====
// Self-checking bench for the receiver control block.
// Assumes host_model and the design files are compiled first.
`timescale 1ns/10ps
`include "rx_ctrl_params.svh"

module test_receiver_control_logic;
  import rx_ctrl_pkg::*;

  logic         mclk, rst_n, ce, mrt_expire, framing_pick_pm;
  logic         squelch_step, am_digital, pm_digital;
  logic         rx_window, meas_gate, framing_data, gain_reset_pulse;
  logic [7:0]   rd_data, rv;
  reg_req_t     reg_req;
  cmd_t         cmd;
  proto_t       proto_mode;
  analog_ctrl_t analog_ctrl;
  filter_sel_t  filter_sel;
  int           n_fail, n_checks;

  // Expected filter decode, indexed by scenario step
  logic [2:0] zc[6] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h3, 3'h5};
  logic [2:0] lc[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h0};
  zero1_t e1[6] = '{ZERO1_60K, ZERO1_60K, ZERO1_40K, ZERO1_12K,
                    ZERO1_12K, ZERO1_12K};
  zero3_t e3[6] = '{ZERO3_400K, ZERO3_200K, ZERO3_80K, ZERO3_200K,
                    ZERO3_80K, ZERO3_200K};
  lp_t    el[6] = '{LP_1200K, LP_600K, LP_300K, LP_2M, LP_7M, LP_1200K};
  // Preset results from a start value of C9; last two must not move
  logic [7:0] pv[8] = '{8'hC0, 8'hC4, 8'hC4, 8'hE2, 8'hC5, 8'hC3,
                        8'hC9, 8'hC9};

  // ----------------------------------------------------------------
  // Clock, instances
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  host_model u_host (.mclk(mclk), .rd_data(rd_data), .reg_req(reg_req),
                     .cmd(cmd));

  receiver_control_logic u_dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
    .rd_data(rd_data), .cmd(cmd), .proto_mode(proto_mode),
    .mrt_expire(mrt_expire), .framing_pick_pm(framing_pick_pm),
    .squelch_step(squelch_step), .am_digital(am_digital),
    .pm_digital(pm_digital), .analog_ctrl(analog_ctrl),
    .filter_sel(filter_sel), .rx_window(rx_window),
    .meas_gate(meas_gate), .framing_data(framing_data),
    .gain_reset_pulse(gain_reset_pulse));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Let n edges land, then step off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic expect_reg(input logic [2:0] a, input logic [7:0] e);
    u_host.read_reg(a, rv);
    chk("register read", e, rv);
  endtask : expect_reg

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("stage1_red", 8'h06, analog_ctrl.stage1_red);
    chk("power_en", 8'h00, analog_ctrl.power_en);
    chk("rx_window", 8'h00, rx_window);
    expect_reg(`OFF_RX_CONF3, 8'hC0);
    expect_reg(`OFF_FILTER_CFG, 8'h00);
    expect_reg(3'h7, 8'h00);
  endtask : t_reset

  task automatic t_enables;
    u_host.write_reg(`OFF_OP_CTRL, 8'h40);
    @(posedge mclk) framing_pick_pm <= 1'b1;
    settle(2);
    chk("power_en", 8'h01, analog_ctrl.power_en);
    chk("both chans", 8'h03, {analog_ctrl.am_en, analog_ctrl.pm_en});
    chk("auto pick pm", 8'h01, analog_ctrl.chan_pm);
    @(posedge mclk) framing_pick_pm <= 1'b0;
    settle(2);
    chk("auto pick am", 8'h00, analog_ctrl.chan_pm);
    u_host.write_reg(`OFF_FILTER_CFG, 8'h40);
    u_host.write_reg(`OFF_OP_CTRL, 8'h50);
    settle(1);
    chk("manual pm", 8'h01, analog_ctrl.chan_pm);
    u_host.write_reg(`OFF_OP_CTRL, 8'h60);
    settle(1);
    chk("one chan", 8'h01, analog_ctrl.am_en ^ analog_ctrl.pm_en);
    u_host.write_reg(`OFF_OP_CTRL, 8'h00);
    settle(1);
    chk("power off", 8'h00, analog_ctrl.power_en);
  endtask : t_enables

  task automatic t_window;
    u_host.write_reg(`OFF_FILTER_CFG, 8'h00);
    u_host.write_reg(`OFF_OP_CTRL, 8'h50);
    @(posedge mclk) am_digital <= 1'b1;
    @(posedge mclk) mrt_expire <= 1'b1;
    @(posedge mclk) mrt_expire <= 1'b0;
    #1 chk("window open", 8'h01, rx_window);
    settle(1);
    chk("framing am", 8'h01, framing_data);
    chk("meas gate", 8'h01, meas_gate);
    u_host.send_cmd(`CMD_MASK_RX);
    #1 chk("window mask", 8'h00, rx_window);
    settle(1);
    chk("framing off", 8'h00, framing_data);
    chk("gate off", 8'h00, meas_gate);
    u_host.send_cmd(`CMD_UNMASK_RX);
    #1 chk("window unmask", 8'h01, rx_window);
  endtask : t_window

  // Clock enable low must swallow a mask command
  task automatic t_freeze;
    @(posedge mclk) ce <= 1'b0;
    u_host.send_cmd(`CMD_MASK_RX);
    settle(1);
    chk("frozen window", 8'h01, rx_window);
    @(posedge mclk) ce <= 1'b1;
    settle(1);
    chk("window kept", 8'h01, rx_window);
  endtask : t_freeze

  task automatic t_filter;
    for (int i = 0; i < 6; i++) begin
      u_host.write_reg(`OFF_FILTER_CFG, {i[0], 1'b0, lc[i], zc[i]});
      settle(1);
      chk("use_mixer", i[0], analog_ctrl.use_mixer);
      chk("first_zero", e1[i], filter_sel.first_zero);
      chk("third_zero", e3[i], filter_sel.third_zero);
      chk("lowpass", el[i], filter_sel.lowpass);
      chk("code_unused", 8'h00, filter_sel.code_unused);
    end
    u_host.write_reg(`OFF_FILTER_CFG, 8'h07);
    settle(1);
    chk("zero unused", 8'h01, filter_sel.code_unused);
    u_host.write_reg(`OFF_FILTER_CFG, 8'h18);
    settle(1);
    chk("lp unused", 8'h01, filter_sel.code_unused);
  endtask : t_filter

  task automatic t_gain;
    u_host.write_reg(`OFF_RX_CONF2, 8'h80);
    settle(1);
    chk("lf_bypass", 8'h01, analog_ctrl.lf_bypass);
    u_host.write_reg(`OFF_RX_CONF3, 8'h30);
    u_host.write_reg(`OFF_RX_CONF4, 8'h30);
    u_host.send_cmd(`CMD_RESET_GAIN);
    #1 chk("gain pulse", 8'h01, gain_reset_pulse);
    settle(1);
    chk("pulse end", 8'h00, gain_reset_pulse);
    chk("stage23_red", 8'h03, analog_ctrl.stage23_red);
    chk("stage1_red", 8'h01, analog_ctrl.stage1_red);
    chk("boost", 8'h01, analog_ctrl.stage1_boost);
    u_host.write_reg(`OFF_RX_CONF4, 8'h90);
    u_host.send_cmd(`CMD_RESET_GAIN);
    settle(2);
    chk("stage23 cap", 8'h06, analog_ctrl.stage23_red);
    u_host.write_reg(`OFF_RX_CONF4, 8'h00);
    u_host.send_cmd(`CMD_RESET_GAIN);
    @(posedge mclk) squelch_step <= 1'b1;
    settle(8);
    chk("squelch cap", 8'h06, analog_ctrl.stage23_red);
    expect_reg(`OFF_RX_STATUS, 8'hB6);
    u_host.send_cmd(`CMD_RESET_GAIN);
    squelch_step <= 1'b0;
    settle(2);
    chk("squelch clear", 8'h01, analog_ctrl.stage23_red);
  endtask : t_gain

  task automatic t_preset;
    for (int p = 0; p < 8; p++) begin
      u_host.write_reg(`OFF_FILTER_CFG, 8'hC9);
      @(posedge mclk) proto_mode <= proto_t'(p[2:0]);
      u_host.send_cmd(`CMD_ANALOG_PRE);
      expect_reg(`OFF_FILTER_CFG, pv[p]);
    end
  endtask : t_preset

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    mrt_expire = 1'b0;
    framing_pick_pm = 1'b0;
    squelch_step = 1'b0;
    am_digital = 1'b0;
    pm_digital = 1'b0;
    proto_mode = PROTO_ISO_A_128;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    settle(2);
    t_reset();
    t_enables();
    t_window();
    t_freeze();
    t_filter();
    t_gain();
    t_preset();
    test_done();
  end

  // A stuck sequence counts as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    test_done();
  end

endmodule : test_receiver_control_logic
